// ### design/lpss_pkg.sv
// Constants for the low-power state sequencer
package lpss_pkg;

    // ***************************************
    // Clock gate vector bit positions
    // ***************************************
    localparam int GATE_W       = 4;
    localparam int GATE_CORE    = 0;
    localparam int GATE_BUS     = 1;
    localparam int GATE_INTUNIT = 2;
    localparam int GATE_PLL     = 3;

    localparam logic [3:0] GATES_RUN   = 4'hF;
    localparam logic [3:0] GATES_HALT  = 4'hE;
    localparam logic [3:0] GATES_SLEEP = 4'h8;
    localparam logic [3:0] GATES_DEEP  = 4'h0;

    // ***************************************
    // Acknowledge transaction codes
    // ***************************************
    localparam int ACK_W = 2;
    localparam logic [1:0] ACK_NONE = 2'h0;
    localparam logic [1:0] ACK_HALT = 2'h1;
    localparam logic [1:0] ACK_MGMT = 2'h2;

    // Trip threshold in degrees C
    localparam int TRIP_TEMP_C = 125;
    localparam int TEMP_W      = 8;

    typedef enum logic [2:0] {
        LPSS_RUN   = 3'h0,
        LPSS_HALT  = 3'h1,
        LPSS_SLEEP = 3'h3,
        LPSS_DEEP  = 3'h2,
        LPSS_TRIP  = 3'h6
    } lpss_state_e;

endpackage

// ### design/lpss_sequencer.sv
// Low-power state sequencer: power states, clock gates, acknowledges, trip
`timescale 1ns/1ps
`default_nettype none
module lpss_sequencer
    import lpss_pkg::*;
(
    input  wire logic                        clk,
    input  wire logic                        sys_rst,
    input  wire logic                        clock_halt_request_n,
    input  wire logic                        sleep_request_n,
    input  wire logic                        deep_sleep_request_n,
    input  wire logic                        mgmt_interrupt_n,
    input  wire logic                        snoopReq,
    input  wire logic                        intReq,
    input  wire logic                        busClkPresent,
    input  wire logic                        handlerDone,
    input  wire logic [lpss_pkg::TEMP_W-1:0] junctionTemp,
    output logic      [lpss_pkg::GATE_W-1:0] clkGate,
    output logic                             ackValid,
    output logic      [lpss_pkg::ACK_W-1:0]  ackCode,
    output logic                             busOutEn,
    output logic                             execRun,
    output logic                             saveState,
    output logic                             privileged_mgmt_mode,
    output logic                             snoopAck,
    output logic                             intAck,
    output logic                             overheat_trip_n,
    output logic                             low_power_status_n
);
    import lpss_pkg::*;

    // ***************************************
    // Input synchronisers
    // ***************************************
    logic [5:0] syncA_reg;
    logic [5:0] syncB_reg;
    logic haltReq;
    logic sleepReq;
    logic deepReq;
    logic mgmtReq;
    logic snoopIn;
    logic clkIn;

    always_ff @(posedge clk) begin
        syncA_reg <= {busClkPresent, snoopReq, ~mgmt_interrupt_n, ~deep_sleep_request_n,
                      ~sleep_request_n, ~clock_halt_request_n};
        syncB_reg <= syncA_reg;
    end

    assign haltReq  = syncB_reg[0];
    assign sleepReq = syncB_reg[1];
    assign deepReq  = syncB_reg[2];
    assign mgmtReq  = syncB_reg[3];
    assign snoopIn  = syncB_reg[4];
    assign clkIn    = syncB_reg[5];

    // ***************************************
    // Power state machine
    // ***************************************
    lpss_state_e state_reg;
    lpss_state_e state_next;
    logic        hot;

    assign hot = junctionTemp > TEMP_W'(TRIP_TEMP_C);

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            LPSS_RUN: begin
                if (haltReq) begin
                    state_next = LPSS_HALT;
                end
            end
            LPSS_HALT: begin
                if (sleepReq) begin
                    state_next = LPSS_SLEEP;
                end else if (!haltReq) begin
                    state_next = LPSS_RUN;
                end
            end
            LPSS_SLEEP: begin
                // Only wake or deepen count here; lost bus clock and trip are handled below
                if (deepReq) begin
                    state_next = LPSS_DEEP;
                end else if (!sleepReq) begin
                    state_next = LPSS_HALT;
                end
            end
            LPSS_DEEP: begin
                // Wait for the bus clock too, or a lost clock bounces Sleep and Deep
                if (!deepReq && clkIn) begin
                    state_next = LPSS_SLEEP;
                end
            end
            LPSS_TRIP: begin
                state_next = LPSS_TRIP;
            end
            default: begin
                state_next = LPSS_RUN;
            end
        endcase
        // Losing the bus clock from Sleep falls straight to Deep Sleep
        if (state_reg == LPSS_SLEEP && !clkIn) begin
            state_next = LPSS_DEEP;
        end
        if (hot) begin
            state_next = LPSS_TRIP;
        end
    end
    // Sleep requests outside halt-grant fall through unchanged

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_reg <= LPSS_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // ***************************************
    // Clock gates and status
    // ***************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            clkGate            <= GATES_RUN;
            low_power_status_n <= 1'b1;
            overheat_trip_n    <= 1'b1;
        end else begin
            unique case (state_next)
                LPSS_HALT:  clkGate <= GATES_HALT;
                LPSS_SLEEP: clkGate <= GATES_SLEEP;
                LPSS_DEEP:  clkGate <= GATES_DEEP;
                LPSS_TRIP:  clkGate <= GATES_DEEP;
                default:    clkGate <= GATES_RUN;
            endcase
            low_power_status_n <= !(state_next == LPSS_DEEP);
            overheat_trip_n    <= !(state_next == LPSS_TRIP);
        end
    end

    // ***************************************
    // Snoop and interrupt service
    // ***************************************
    // Awake means clocks still reach the bus unit
    function automatic logic isAwake(lpss_state_e s);
        return (s == LPSS_RUN) || (s == LPSS_HALT);
    endfunction

    logic awake;
    logic awakeNext;
    assign awake     = isAwake(state_reg);
    assign awakeNext = isAwake(state_next);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            snoopAck <= 1'b0;
            intAck   <= 1'b0;
        end else begin
            // Deaf in Sleep and below
            snoopAck <= awake && snoopIn;
            intAck   <= awake && intReq && !intAck;
        end
    end

    // ***************************************
    // Management mode entry
    // ***************************************
    logic mgmtPrev_reg;
    logic ackPend_reg;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            mgmtPrev_reg         <= 1'b0;
            privileged_mgmt_mode <= 1'b0;
            saveState            <= 1'b0;
            ackPend_reg          <= 1'b0;
        end else begin
            mgmtPrev_reg <= mgmtReq;
            saveState    <= 1'b0;
            // Refused on the edge into Sleep, where its ack could never go out
            if (awake && awakeNext && mgmtReq && !mgmtPrev_reg && !privileged_mgmt_mode) begin
                saveState            <= 1'b1;
                privileged_mgmt_mode <= 1'b1;
                ackPend_reg          <= 1'b1;
            end else if (handlerDone && privileged_mgmt_mode && !ackPend_reg) begin
                privileged_mgmt_mode <= 1'b0;
            end else if (ackPend_reg && ackValid && ackCode == ACK_MGMT) begin
                ackPend_reg <= 1'b0;
            end
        end
    end

    // ***************************************
    // Acknowledge transactions
    // ***************************************
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ackValid <= 1'b0;
            ackCode  <= ACK_NONE;
        end else begin
            ackValid <= 1'b0;
            ackCode  <= ACK_NONE;
            if (state_reg == LPSS_RUN && state_next == LPSS_HALT) begin
                ackValid <= 1'b1;
                ackCode  <= ACK_HALT;
            end else if (ackPend_reg && !ackValid && awake) begin
                ackValid <= 1'b1;
                ackCode  <= ACK_MGMT;
            end
        end
    end

    // Handler runs only after its acknowledge went out
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            execRun <= 1'b0;
        end else begin
            execRun <= (state_next == LPSS_RUN) && !ackPend_reg;
        end
    end

    // ***************************************
    // Bus output enable
    // ***************************************
    // Reset drops the enable on the next edge, inside the two-clock limit
    logic rstPrev_reg;
    logic tristate_reg;

    always_ff @(posedge clk) begin
        rstPrev_reg <= sys_rst;
        if (sys_rst) begin
            busOutEn <= 1'b0;
        end else begin
            busOutEn <= !tristate_reg && !(rstPrev_reg && mgmtReq);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tristate_reg <= 1'b0;
        end else if (rstPrev_reg && mgmtReq) begin
            tristate_reg <= 1'b1;
        end
    end

endmodule
`default_nettype wire

// ### bench/lpss_sequencer_sva.sv
// Port assertions for the low-power state sequencer
`timescale 1ns/1ps
`default_nettype none
module lpss_sequencer_sva
    import lpss_pkg::*;
(
    input wire logic                        clk,
    input wire logic                        sys_rst,
    input wire logic [lpss_pkg::TEMP_W-1:0] junctionTemp,
    input wire logic [lpss_pkg::GATE_W-1:0] clkGate,
    input wire logic                        ackValid,
    input wire logic [lpss_pkg::ACK_W-1:0]  ackCode,
    input wire logic                        busOutEn,
    input wire logic                        execRun,
    input wire logic                        saveState,
    input wire logic                        snoopAck,
    input wire logic                        intAck,
    input wire logic                        overheat_trip_n,
    input wire logic                        low_power_status_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // ****************
    // Checks
    // ****************
    a_halt_ack_pulse: assert property (clkGate == GATES_HALT && $past(clkGate) == GATES_RUN
        |-> ackValid && ackCode == ACK_HALT) else $error("halt entry without grant ack");
    a_halt_no_exec: assert property (clkGate == GATES_HALT |-> !execRun) else $error("exec in halt");
    a_sleep_quiet: assert property (clkGate == GATES_SLEEP [*3]
        |-> !intAck && !snoopAck) else $error("sleep answered a request");
    a_sleep_entry: assert property (clkGate == GATES_SLEEP && $past(clkGate) != GATES_SLEEP
        |-> $past(clkGate) == GATES_HALT || $past(clkGate) == GATES_DEEP) else $error("bad sleep entry");
    a_mgmt_ack: assert property (saveState |-> ##[1:2] ackValid && ackCode == ACK_MGMT)
        else $error("no mgmt ack");
    a_deep_status: assert property ((clkGate == GATES_DEEP && overheat_trip_n)
        == !low_power_status_n) else $error("status indicator wrong");
    a_trip_raise: assert property (junctionTemp > TRIP_TEMP_C |-> ##[1:3] !overheat_trip_n)
        else $error("no trip");
    a_trip_stops: assert property (!overheat_trip_n |-> !execRun && clkGate == GATES_DEEP
        ##1 !overheat_trip_n) else $error("trip not halting");
    a_reset_release: assert property (disable iff (1'b0) $rose(sys_rst) |-> ##[0:2] !busOutEn)
        else $error("bus outputs kept");
    c_sleep: cover property (clkGate == GATES_SLEEP);
    c_trip: cover property (!overheat_trip_n);
    c_deep: cover property (!low_power_status_n);
    c_mgmt: cover property (ackValid && ackCode == ACK_MGMT);
endmodule
`default_nettype wire

// ### bench/lpss_platform_model.sv
// Platform logic model driving the power-state request pins
`timescale 1ns/1ps
`default_nettype none
module lpss_platform_model (
    input  wire logic       clk,
    input  wire logic [1:0] wantLevel,
    input  wire logic       rogueSleep,
    output logic            clock_halt_request_n,
    output logic            sleep_request_n,
    output logic            deep_sleep_request_n
);
    logic [1:0] level_reg = 2'h0;
    logic [2:0] gap_reg   = 3'h0;
    // Slow steps let the halt sync settle before the next request
    always @(negedge clk) begin
        gap_reg <= gap_reg + 3'h1;
        // One level per step, so release always comes in reverse order
        if (gap_reg == 3'h7 && level_reg < wantLevel) begin
            level_reg <= level_reg + 2'h1;
        end else if (gap_reg == 3'h7 && level_reg > wantLevel) begin
            level_reg <= level_reg - 2'h1;
        end
    end
    assign clock_halt_request_n = !(level_reg >= 2'h1);
    assign sleep_request_n      = !(level_reg >= 2'h2 || rogueSleep);
    assign deep_sleep_request_n = !(level_reg == 2'h3);
endmodule
`default_nettype wire

// ### bench/tb_top.sv
// Testbench for the low-power state sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import lpss_pkg::*;
    logic       clk = 1'b0, sys_rst = 1'b1, mgmtN = 1'b1, snoop = 1'b0, intr = 1'b0;
    logic       bclk = 1'b1, done = 1'b0, rogue = 1'b0;
    logic [1:0] want = 2'h0;
    logic [7:0] temp = 8'h14, rnd = 8'h49;
    logic [3:0] gate;
    logic [1:0] code;
    logic       haltN, slpN, deepN, ackV, busEn, exec, mode, sAck, iAck, tripN, statN;
    logic [1:0] expQ[$];
    int         fails = 0, n_checks = 0, i;
    lpss_platform_model plat (.clk(clk), .wantLevel(want), .rogueSleep(rogue), .clock_halt_request_n(haltN),
        .sleep_request_n(slpN), .deep_sleep_request_n(deepN));
    lpss_sequencer dut (.clk(clk), .sys_rst(sys_rst), .clock_halt_request_n(haltN), .sleep_request_n(slpN),
        .deep_sleep_request_n(deepN), .mgmt_interrupt_n(mgmtN), .snoopReq(snoop), .intReq(intr),
        .busClkPresent(bclk), .handlerDone(done), .junctionTemp(temp), .clkGate(gate), .ackValid(ackV),
        .ackCode(code), .busOutEn(busEn), .execRun(exec), .saveState(), .privileged_mgmt_mode(mode),
        .snoopAck(sAck), .intAck(iAck), .overheat_trip_n(tripN), .low_power_status_n(statN));
    initial forever #4 clk = ~clk;
    // Bench random source, seeded with 73
    function automatic logic [7:0] lfsrNext(logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic waitGate(logic [3:0] e);
        for (i = 0; i < 80 && gate !== e; i++) @(negedge clk);
        chk("clkGate", {4'h0, e}, {4'h0, gate});
    endtask
    task automatic stop_test;
        $display("checks %0d fails %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Acks only count while the bus is driven; looked at mid-cycle, where they stand
    always @(negedge clk) begin
        if (!sys_rst && busEn === 1'b1 && ackV === 1'b1) begin
            if (expQ.size() == 0) chk("unexpected ack", 8'h0, {6'h0, code});
            else chk("ackCode", {6'h0, expQ.pop_front()}, {6'h0, code});
        end
    end
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        stop_test();
    end
    initial begin
        repeat (12) @(negedge clk);
        sys_rst = 1'b0;
        repeat (4) @(negedge clk);
        rogue = 1'b1;
        repeat (12) @(negedge clk);
        chk("clkGate", 8'h0F, {4'h0, gate});
        rogue = 1'b0;
        snoop = 1'b1;
        want = 2'h1;
        expQ.push_back(ACK_HALT);
        waitGate(GATES_HALT);
        chk("execRun", 8'h0, {7'h0, exec});
        repeat (4) @(negedge clk);
        chk("snoopAck", 8'h1, {7'h0, sAck});
        want = 2'h2;
        waitGate(GATES_SLEEP);
        intr = 1'b1;
        mgmtN = 1'b0;
        repeat (6) @(negedge clk);
        chk("sleep acks", 8'h0, {6'h0, sAck, iAck});
        chk("mgmt mode", 8'h0, {7'h0, mode});
        mgmtN = 1'b1;
        want = 2'h3;
        waitGate(GATES_DEEP);
        chk("status", 8'h0, {7'h0, statN});
        want = 2'h2;
        waitGate(GATES_SLEEP);
        chk("status", 8'h1, {7'h0, statN});
        bclk = 1'b0;
        waitGate(GATES_DEEP);
        bclk = 1'b1;
        waitGate(GATES_SLEEP);
        want = 2'h1;
        waitGate(GATES_HALT);
        want = 2'h0;
        waitGate(GATES_RUN);
        repeat (3) @(negedge clk);
        chk("execRun", 8'h1, {7'h0, exec});
        expQ.push_back(ACK_MGMT);
        mgmtN = 1'b0;
        repeat (8) @(negedge clk);
        chk("mode", 8'h1, {7'h0, mode});
        mgmtN = 1'b1;
        done = 1'b1;
        @(negedge clk);
        done = 1'b0;
        chk("mode", 8'h0, {7'h0, mode});
        for (int k = 0; k < 24; k++) begin
            rnd = lfsrNext(rnd);
            temp = rnd % 8'h7E;
            intr = rnd[0];
            snoop = rnd[1];
            @(negedge clk);
            chk("trip idle", 8'h1, {7'h0, tripN});
        end
        temp = 8'h7E;
        repeat (5) @(negedge clk);
        chk("trip", 8'h0, {7'h0, tripN});
        chk("execRun", 8'h0, {7'h0, exec});
        temp = 8'h14;
        sys_rst = 1'b1;
        mgmtN = 1'b0;
        repeat (2) @(negedge clk);
        chk("busOutEn", 8'h0, {7'h0, busEn});
        repeat (10) @(negedge clk);
        sys_rst = 1'b0;
        repeat (6) @(negedge clk);
        mgmtN = 1'b1;
        repeat (6) @(negedge clk);
        chk("busOutEn", 8'h0, {7'h0, busEn});
        sys_rst = 1'b1;
        repeat (12) @(negedge clk);
        sys_rst = 1'b0;
        repeat (6) @(negedge clk);
        chk("busOutEn", 8'h1, {7'h0, busEn});
        chk("queue", 8'h0, 8'(expQ.size()));
        stop_test();
    end
endmodule
bind lpss_sequencer lpss_sequencer_sva chk_i (.clk(clk), .sys_rst(sys_rst), .junctionTemp(junctionTemp),
    .clkGate(clkGate), .ackValid(ackValid), .ackCode(ackCode), .busOutEn(busOutEn), .execRun(execRun),
    .saveState(saveState), .snoopAck(snoopAck), .intAck(intAck), .overheat_trip_n(overheat_trip_n),
    .low_power_status_n(low_power_status_n));
`default_nettype wire
